// [rtl/msbr_pkg.sv]
// package: register indices, field positions, timing for the bridge readout
package msbr_pkg;
   // register indices on the link (one 16-bit word each)
   localparam logic [3:0]  REG_MODULE_STATE = 4'h0;
   localparam logic [3:0]  REG_SAMPLE_BASE  = 4'h1;  // slots 1..10 at 1..10
   localparam logic [3:0]  REG_RANGE_SELECT = 4'hb;
   localparam logic [3:0]  REG_PERIOD_SEL   = 4'hc;
   localparam int          NUM_SLOTS        = 10;
   localparam int          MIN_SAMPLES      = 3;
   // module_state bit positions
   localparam int          ST_INVALID_BIT   = 0;
   localparam int          ST_OPEN_BIT      = 1;
   localparam int          ST_NOSYNC_BIT    = 2;
   // range_select fields
   localparam int          RS_EXT_BIT       = 2;
   localparam logic [7:0]  RANGE_RESET      = 8'h00;
   localparam logic [7:0]  PERIOD_RESET     = 8'h00;
   localparam logic [7:0]  PERIOD_CODE_50   = 8'h00;
   localparam logic [7:0]  PERIOD_CODE_100  = 8'h01;
   // timing
   localparam int          CLK_MHZ          = 50;
   localparam int          PERIOD_50_US     = 50;
   localparam int          PERIOD_100_US    = 100;
   localparam int          CYC_50           = PERIOD_50_US * CLK_MHZ;
   localparam int          CYC_100          = PERIOD_100_US * CLK_MHZ;
   localparam int          MIN_LINK_US      = 250;
   localparam int          SETTLE_PERIODS   = 150;
   // host-side APB register offsets
   localparam logic [11:0] H_CTRL           = 12'h000;
   localparam logic [11:0] H_STATUS         = 12'h004;
   localparam logic [11:0] H_IRQ_STATUS     = 12'h008;
   localparam logic [11:0] H_IRQ_MASK       = 12'h00c;
   localparam logic [11:0] H_CFG            = 12'h010;
   localparam logic [11:0] H_SAMPLE_BASE    = 12'h040;
   // full-scale range in mV/V from a 3-bit code
   function automatic logic [8:0] range_mvv(input logic [2:0] code);
      logic [8:0] base;
      base = code[RS_EXT_BIT] ? 9'h100 : 9'h010;
      return base >> code[1:0];
   endfunction : range_mvv
endpackage : msbr_pkg

// [rtl/msbr_link_if.sv]
// interface: cyclic link between the bridge readout and its master
interface msbr_link_if;
   logic        cycle_start;  // one-cycle pulse, master opens a link cycle
   logic [9:0]  cycle_us;     // link cycle time in microseconds
   logic        wr_en;
   logic [3:0]  wr_idx;
   logic [7:0]  wr_data;
   logic        rd_en;
   logic [3:0]  rd_idx;
   logic [15:0] rd_data;
   logic        rd_valid;
   logic        frame_done;   // one-cycle pulse, new frame latched
   modport dev  (input cycle_start, cycle_us, wr_en, wr_idx, wr_data,
                 rd_en, rd_idx, output rd_data, rd_valid, frame_done);
   modport host (output cycle_start, cycle_us, wr_en, wr_idx, wr_data,
                 rd_en, rd_idx, input rd_data, rd_valid, frame_done);
endinterface : msbr_link_if

// [rtl/msbr_device.sv]
// device end: multiple-sampling bridge readout
// Summary of operation
// RULE1: status bit0 high when latest value invalid
// RULE2: status bit1 set on open bridge this cycle
// RULE3: open bit clears itself when conversions good
// RULE4: status bit2 low only while synchronised
// RULE5: unsynced while settling or period misaligned
// RULE6: status bits 3 to 7 read zero
// RULE7: each result a 16-bit raw slot value
// RULE8: three to ten results per link cycle
// RULE9: standard codes give 16,8,4,2 mV/V
// RULE10: extended codes give 256,128,64,32 mV/V
// RULE11: master writes zero to range bits 3-7
// RULE12: open detection trusted in standard ranges only
// RULE13: period code 0 is 50us, 1 is 100us
// RULE14: master cycle is multiple of converter period
// RULE15: at 50us count is cycle/50, max ten
// RULE16: at 100us count is cycle/100, max ten
// RULE17: master cycle not shorter than 250us
// RULE18: inputs refresh every converter period
module msbr_device #(
   parameter int SETTLE = msbr_pkg::SETTLE_PERIODS
) (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   msbr_link_if.dev         link,
   input  wire logic [15:0] adc_data_i,
   input  wire logic        adc_open_i,
   input  wire logic        adc_error_i,
   output logic [8:0]       range_mvv_o,
   output logic             open_reliable_o,
   output logic             conv_strobe_o
);
   initial begin
      if (SETTLE < 1 || SETTLE > 255) $error("SETTLE out of range");
   end

   // --------------------------------------------------------------------
   // state
   // --------------------------------------------------------------------
   // slot count must be known before the state struct is laid out
   localparam int NUM_S = msbr_pkg::NUM_SLOTS;

   // cur fills during a link cycle, frm is what the master reads back;
   // two copies keep a read stable while the next cycle is sampled
   typedef struct packed {
      logic [12:0] tick;
      logic [3:0]  slot;
      logic        open_cur;
      logic        open_flag;
      logic        invalid;
      logic        nosync;
      logic [7:0]  settle;
      logic [7:0]  range;
      logic [7:0]  period;
      logic [15:0] rd_data;
      logic        rd_valid;
      logic        frame_done;
      logic [8:0]  rng_mvv;
      logic        open_rel;
      logic        strobe;
      logic [NUM_S-1:0][15:0] cur;
      logic [NUM_S-1:0][15:0] frm;
   } msbr_dev_s;

   msbr_dev_s s_reg, s_next;
   logic [12:0] per_cyc;
   logic        is100;
   logic [3:0]  want;
   logic        aligned;

   // --------------------------------------------------------------------
   // period decode and expected count
   // --------------------------------------------------------------------
   always_comb begin
      is100   = (s_reg.period == msbr_pkg::PERIOD_CODE_100); // RULE13
      per_cyc = is100 ? 13'(msbr_pkg::CYC_100) : 13'(msbr_pkg::CYC_50);
      // count = cycle/period capped at ten
      if (is100) begin // RULE16
         want = (link.cycle_us >= 10'd1000) ? 4'd10
              : 4'(link.cycle_us / 10'd100);
      end else begin // RULE15
         want = (link.cycle_us >= 10'd500) ? 4'd10
              : 4'(link.cycle_us / 10'd50);
      end
      if (want < 4'(msbr_pkg::MIN_SAMPLES)) begin // RULE8
         want = 4'(msbr_pkg::MIN_SAMPLES);
      end
      // misaligned cycle cannot be tracked, report unsynced
      aligned = is100 ? (link.cycle_us % 10'd100 == 10'd0) // RULE14
                      : (link.cycle_us % 10'd50 == 10'd0);
   end

   // --------------------------------------------------------------------
   // next state
   // --------------------------------------------------------------------
   always_comb begin
      s_next            = s_reg;
      s_next.rd_valid   = 1'b0;
      s_next.frame_done = 1'b0;
      s_next.strobe     = 1'b0;
      s_next.rng_mvv    = msbr_pkg::range_mvv(s_reg.range[2:0]); // RULE9 RULE10
      s_next.open_rel   = ~s_reg.range[msbr_pkg::RS_EXT_BIT]; // RULE12
      // converter period tick
      if (s_reg.tick >= per_cyc - 13'd1) begin
         s_next.tick = 13'd0;
      end else begin
         s_next.tick = s_reg.tick + 13'd1;
      end
      if (s_reg.tick == 13'd0) begin // RULE18
         s_next.strobe  = 1'b1;
         s_next.invalid = adc_error_i; // RULE1
         if (s_reg.slot < 4'(NUM_S)) begin
            s_next.cur[s_reg.slot] = adc_data_i; // RULE7
            s_next.slot = s_reg.slot + 4'd1;
         end
         if (adc_open_i) begin
            s_next.open_cur = 1'b1;
         end
         if (s_reg.settle != 8'd0) begin
            s_next.settle = s_reg.settle - 8'd1;
         end
      end
      s_next.nosync = (s_reg.settle != 8'd0) || !aligned; // RULE4 RULE5
      if (link.cycle_start) begin
         // latch only as many slots as the cycle can fill
         for (int i = 0; i < NUM_S; i++) begin
            s_next.frm[i] = (4'(i) < want) ? s_reg.cur[i] : 16'h0000; // RULE8
         end
         s_next.open_flag  = s_reg.open_cur | adc_open_i; // RULE2 RULE3
         s_next.open_cur   = 1'b0;
         s_next.slot       = 4'd0;
         s_next.frame_done = 1'b1;
      end
      if (link.wr_en) begin
         if (link.wr_idx == msbr_pkg::REG_RANGE_SELECT) begin
            s_next.range = link.wr_data;
         end
         if (link.wr_idx == msbr_pkg::REG_PERIOD_SEL) begin
            s_next.period = link.wr_data;
            // a period change restarts settling
            s_next.settle = 8'(SETTLE);
         end
      end
      if (link.rd_en) begin
         s_next.rd_valid = 1'b1;
         if (link.rd_idx == msbr_pkg::REG_MODULE_STATE) begin
            s_next.rd_data = {13'h0000, s_reg.nosync, s_reg.open_flag,
                              s_reg.invalid}; // RULE6
         end else if (link.rd_idx >= msbr_pkg::REG_SAMPLE_BASE &&
                      link.rd_idx <= 4'(NUM_S)) begin
            s_next.rd_data = s_reg.frm[link.rd_idx - 4'd1];
         end else if (link.rd_idx == msbr_pkg::REG_RANGE_SELECT) begin
            s_next.rd_data = {8'h00, s_reg.range};
         end else if (link.rd_idx == msbr_pkg::REG_PERIOD_SEL) begin
            s_next.rd_data = {8'h00, s_reg.period};
         end else begin
            s_next.rd_data = 16'h0000;
         end
      end
   end

   // --------------------------------------------------------------------
   // registers
   // --------------------------------------------------------------------
   // reset reports invalid until the first tick and unsynced until the settle count runs out
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s_reg        <= '0;
         s_reg.range  <= msbr_pkg::RANGE_RESET;
         s_reg.period <= msbr_pkg::PERIOD_RESET;
         s_reg.settle <= 8'(SETTLE);
         s_reg.nosync <= 1'b1;
         s_reg.invalid <= 1'b1;
         s_reg.rng_mvv <= 9'h010;
         s_reg.open_rel <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // --------------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------------
   // every output is a bare register bit, no logic after the flops
   assign link.rd_data    = s_reg.rd_data;
   assign link.rd_valid   = s_reg.rd_valid;
   assign link.frame_done = s_reg.frame_done;
   assign range_mvv_o     = s_reg.rng_mvv;
   assign open_reliable_o = s_reg.open_rel;
   assign conv_strobe_o   = s_reg.strobe;
endmodule : msbr_device

// [rtl/msbr_host.sv]
// host end: link master with APB registers and interrupt
module msbr_host (
   input  wire logic        sys_clk_i,
   input  wire logic        reset_n_i,
   msbr_link_if.host        link,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             irq_o
);
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00, HS_READ = 2'b01, HS_WAIT = 2'b10
   } msbr_hst_e;

   typedef struct packed {
      msbr_hst_e   st;
      logic [19:0] cnt;
      logic        cs;
      logic [9:0]  cyc_us;
      logic [7:0]  range;
      logic [7:0]  period;
      logic        cfg_go;
      logic [3:0]  idx;
      logic [10:0][15:0] buf_;
      logic [2:0]  irq_st;
      logic [2:0]  irq_mask;
      logic        wr_en;
      logic [3:0]  wr_idx;
      logic [7:0]  wr_data;
      logic        rd_en;
      logic        busy;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
   } msbr_hst_s;

   msbr_hst_s h_reg, h_next;
   logic [19:0] cyc_clk;
   logic [2:0]  ev;
   logic        acc;

   always_comb begin
      h_next = h_reg;
      h_next.cs = 1'b0;
      h_next.wr_en = 1'b0;
      h_next.rd_en = 1'b0;
      h_next.pready = 1'b0;
      h_next.pslverr = 1'b0;
      ev = 3'b000;
      acc = psel_i & penable_i & ~h_reg.pready;
      // cycle never below the device minimum
      cyc_clk = (h_reg.cyc_us < 10'(msbr_pkg::MIN_LINK_US)) // RULE17
              ? 20'(msbr_pkg::MIN_LINK_US * msbr_pkg::CLK_MHZ)
              : 20'(h_reg.cyc_us) * 20'(msbr_pkg::CLK_MHZ);
      // ------------------------------------------------------------------
      // link cycle generator and frame readback
      // ------------------------------------------------------------------
      if (h_reg.cnt >= cyc_clk - 20'd1) begin
         h_next.cnt = 20'd0;
         h_next.cs = 1'b1;
      end else begin
         h_next.cnt = h_reg.cnt + 20'd1;
      end
      if (h_reg.cfg_go) begin
         h_next.cfg_go = 1'b0;
         h_next.wr_en = 1'b1;
         h_next.wr_idx = msbr_pkg::REG_PERIOD_SEL;
         h_next.wr_data = h_reg.period;
      end else if (h_reg.wr_en && h_reg.wr_idx == msbr_pkg::REG_PERIOD_SEL)
      begin
         h_next.wr_en = 1'b1;
         h_next.wr_idx = msbr_pkg::REG_RANGE_SELECT;
         h_next.wr_data = {5'h00, h_reg.range[2:0]}; // RULE11
      end
      unique case (h_reg.st)
         HS_IDLE: begin
            if (link.frame_done) begin
               h_next.st = HS_READ;
               h_next.idx = 4'd0;
            end
         end
         HS_READ: begin
            h_next.rd_en = 1'b1;
            h_next.st = HS_WAIT;
         end
         HS_WAIT: begin
            if (link.rd_valid) begin
               h_next.buf_[h_reg.idx] = link.rd_data;
               if (h_reg.idx == 4'(msbr_pkg::NUM_SLOTS)) begin
                  h_next.st = HS_IDLE;
                  ev[0] = 1'b1;
                  ev[1] = link.rd_data[msbr_pkg::ST_OPEN_BIT] & 1'b0;
               end else begin
                  h_next.idx = h_reg.idx + 4'd1;
                  h_next.st = HS_READ;
               end
               if (h_reg.idx == 4'd0) begin
                  ev[1] = link.rd_data[msbr_pkg::ST_OPEN_BIT];
                  ev[2] = link.rd_data[msbr_pkg::ST_NOSYNC_BIT];
               end
            end
         end
         default: h_next.st = HS_IDLE;
      endcase
      // ------------------------------------------------------------------
      // apb slave, answers one cycle into the access phase
      // ------------------------------------------------------------------
      if (acc) begin
         h_next.pready = 1'b1;
         h_next.prdata = 32'h0000_0000;
         if (pwrite_i) begin
            unique case (paddr_i)
               msbr_pkg::H_CTRL: h_next.cfg_go = pwdata_i[0];
               msbr_pkg::H_IRQ_MASK: h_next.irq_mask = pwdata_i[2:0];
               msbr_pkg::H_CFG: begin
                  h_next.cyc_us = pwdata_i[9:0];
                  h_next.range = pwdata_i[23:16];
                  h_next.period = pwdata_i[31:24];
               end
               default: h_next.pslverr = 1'b1;
            endcase
         end else if (paddr_i >= msbr_pkg::H_SAMPLE_BASE &&
                      paddr_i < msbr_pkg::H_SAMPLE_BASE + 12'h02c &&
                      paddr_i[1:0] == 2'b00) begin
            h_next.prdata = {16'h0000,
               h_reg.buf_[4'(paddr_i[5:2])]};
         end else begin
            unique case (paddr_i)
               msbr_pkg::H_STATUS:
                  h_next.prdata = {16'h0000, h_reg.buf_[0]};
               msbr_pkg::H_IRQ_STATUS: begin
                  h_next.prdata = {29'h0, h_reg.irq_st};
                  h_next.irq_st = 3'b000;
               end
               msbr_pkg::H_IRQ_MASK: h_next.prdata = {29'h0, h_reg.irq_mask};
               msbr_pkg::H_CFG: h_next.prdata = {h_reg.period, h_reg.range,
                                                 6'h00, h_reg.cyc_us};
               default: h_next.pslverr = 1'b1;
            endcase
         end
      end
      // set wins over read clear
      h_next.irq_st = h_next.irq_st | ev;
      h_next.irq = |(h_next.irq_st & h_reg.irq_mask);
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         h_reg <= '0;
         h_reg.st <= HS_IDLE;
         h_reg.cyc_us <= 10'(msbr_pkg::MIN_LINK_US);
      end else begin
         h_reg <= h_next;
      end
   end

   assign link.cycle_start = h_reg.cs;
   assign link.cycle_us = h_reg.cyc_us;
   assign link.wr_en = h_reg.wr_en;
   assign link.wr_idx = h_reg.wr_idx;
   assign link.wr_data = h_reg.wr_data;
   assign link.rd_en = h_reg.rd_en;
   assign link.rd_idx = h_reg.idx;
   assign prdata_o = h_reg.prdata;
   assign pready_o = h_reg.pready;
   assign pslverr_o = h_reg.pslverr;
   assign irq_o = h_reg.irq;
endmodule : msbr_host

// [dv/msbr_link_chk.sv]
// checker: link handshake and frame content assertions
module msbr_link_chk (
   input wire logic        sys_clk_i,
   input wire logic        reset_n_i,
   input wire logic        cycle_start,
   input wire logic [9:0]  cycle_us,
   input wire logic        wr_en,
   input wire logic [3:0]  wr_idx,
   input wire logic [7:0]  wr_data,
   input wire logic        rd_en,
   input wire logic [3:0]  rd_idx,
   input wire logic [15:0] rd_data,
   input wire logic        rd_valid,
   input wire logic        frame_done
);
   // ---------------------------------------------
   // frame model
   // ---------------------------------------------
   logic [7:0] per_q;  // period code as last written on the link
   int         cnt_q;  // slot count latched at frame start
   logic       mis_q;  // cycle time not a multiple of the period
   int         p_us;
   int         cnt_c;
   always_comb begin
      p_us = (per_q == msbr_pkg::PERIOD_CODE_100) ? 100 : 50;
      cnt_c = int'(cycle_us) / p_us;
      if (cnt_c > msbr_pkg::NUM_SLOTS) cnt_c = msbr_pkg::NUM_SLOTS;
      if (cnt_c < msbr_pkg::MIN_SAMPLES) cnt_c = msbr_pkg::MIN_SAMPLES;
   end
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         per_q <= msbr_pkg::PERIOD_RESET;
         cnt_q <= msbr_pkg::NUM_SLOTS;
         mis_q <= 1'b0;
      end else begin
         if (wr_en && wr_idx == msbr_pkg::REG_PERIOD_SEL) begin
            per_q <= wr_data;
         end
         if (cycle_start) begin
            cnt_q <= cnt_c;
            mis_q <= (int'(cycle_us) % p_us) != 0;
         end
      end
   end
   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_answer;
      ##1 rd_valid;
   endsequence
   sequence s_latched;
      ##1 frame_done ##1 !frame_done [*8];
   endsequence
   a_read_answer: assert property (rd_en |-> s_answer)
      else $error("link read not answered in the next cycle");
   a_read_cause: assert property (rd_valid |-> $past(rd_en))
      else $error("read answer without a read request");
   a_frame_follow: assert property (cycle_start |-> s_latched)
      else $error("frame latch pulse missing or repeated");
   a_frame_cause: assert property (frame_done |-> $past(cycle_start))
      else $error("frame latch pulse without cycle start");
   a_rsvd_zero: assert property (
      rd_valid && $past(rd_idx) == msbr_pkg::REG_MODULE_STATE
      |-> rd_data[7:3] == 5'h00) else $error("reserved status bits set");
   a_slot_empty: assert property (
      rd_valid && $past(rd_idx) != 4'h0 && $past(rd_idx) <= 4'ha
      && int'($past(rd_idx)) > cnt_q |-> rd_data == 16'h0000)
      else $error("slot beyond sample count not zero");
   a_misalign_nosync: assert property (
      rd_valid && $past(rd_idx) == 4'h0 && mis_q
      |-> rd_data[msbr_pkg::ST_NOSYNC_BIT])
      else $error("misaligned cycle reported as synchronous");
   a_data_hold: assert property (!rd_valid |-> $stable(rd_data))
      else $error("read data changed without a read");
endmodule : msbr_link_chk

// [dv/tb.sv]
// testbench: host and device joined, frames checked against a model
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
   err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------
   // signals and instances
   // ---------------------------------------------
   logic        sys_clk_i = 1'b0;
   logic        reset_n_i = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic        pready, pslverr, irq, serr;
   logic [15:0] adc_data = 16'h0000, v;
   logic        adc_open = 1'b0, adc_err = 1'b0, open_rel, conv_stb;
   logic [8:0]  range_mvv;
   int          err_count = 0, num_checks = 0, cyc = 0, e, k;
   always #10 sys_clk_i = ~sys_clk_i;
   msbr_link_if link_if ();
   msbr_device #(.SETTLE(2)) msbr_device_inst (.sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i), .link(link_if), .adc_data_i(adc_data),
      .adc_open_i(adc_open), .adc_error_i(adc_err), .range_mvv_o(range_mvv),
      .open_reliable_o(open_rel), .conv_strobe_o(conv_stb));
   msbr_host msbr_host_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
      .link(link_if), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq));
   msbr_link_chk msbr_link_chk_inst (.sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i), .cycle_start(link_if.cycle_start),
      .cycle_us(link_if.cycle_us), .wr_en(link_if.wr_en),
      .wr_idx(link_if.wr_idx), .wr_data(link_if.wr_data),
      .rd_en(link_if.rd_en), .rd_idx(link_if.rd_idx),
      .rd_data(link_if.rd_data), .rd_valid(link_if.rd_valid),
      .frame_done(link_if.frame_done));
   // ---------------------------------------------
   // tasks and model
   // ---------------------------------------------
   task automatic wrap_up;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   // ceiling covers about seven link cycles plus register traffic
   always @(posedge sys_clk_i) begin
      cyc++;
      if (cyc == 110000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      do @(posedge sys_clk_i); while (pready !== 1'b1);
      r = prdata;
      serr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cfg(input int cy, input int rng, input int per);
      apb(1'b1, msbr_pkg::H_CFG, {8'(per), 8'(rng), 6'h00, 10'(cy)});
      apb(1'b1, msbr_pkg::H_CTRL, 32'h1);
   endtask : cfg
   function automatic int exp_count(input int cy, input int per_us);
      int n;
      n = cy / per_us;
      n = (n > 10) ? 10 : ((n < 3) ? 3 : n);
      return n;
   endfunction : exp_count
   // irq lags the clearing read by a register stage, hence the pause
   task automatic frames(input int n);
      repeat (n) begin
         apb(1'b0, msbr_pkg::H_IRQ_STATUS, 32'h0);
         repeat (2) @(posedge sys_clk_i);
         while (irq !== 1'b1) @(posedge sys_clk_i);
      end
      apb(1'b0, msbr_pkg::H_IRQ_STATUS, 32'h0);
      `CHK("irq_frame", 1'b1, r[0])
      repeat (2) @(posedge sys_clk_i);
      `CHK("irq_clear", 1'b0, irq)
   endtask : frames
   task automatic gap(input int want);
      k = 0;
      while (conv_stb !== 1'b1) @(posedge sys_clk_i);
      do begin
         @(posedge sys_clk_i);
         k++;
      end while (conv_stb !== 1'b1);
      `CHK("tick_gap", want, k)
   endtask : gap
   task automatic check_frame(input logic [7:0] st, input int n,
                              input logic [15:0] val);
      logic [31:0] q[$];
      q = {};
      q.push_back({24'h0, st});
      for (int i = 1; i <= 10; i++) q.push_back(i <= n ? {16'h0, val} : 0);
      for (int i = 0; i <= 10; i++) begin
         apb(1'b0, msbr_pkg::H_SAMPLE_BASE + 12'(4 * i), 32'h0);
         `CHK("frame_word", q.pop_front(), r)
      end
   endtask : check_frame
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      void'($urandom(60));
      repeat (5) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
      @(posedge sys_clk_i);
      `CHK("range_rst", 9'h010, range_mvv)
      apb(1'b0, 12'h7fc, 32'h0);
      `CHK("unmapped", 1'b1, serr)
      apb(1'b1, msbr_pkg::H_IRQ_MASK, 32'h1);
      for (int c = 0; c < 8; c++) begin
         cfg(250, c, 0);
         e = (c[2] ? 256 : 16) >> c[1:0];
         for (k = 0; k < 50 && range_mvv !== 9'(e); k++) @(posedge sys_clk_i);
         `CHK("range", 9'(e), range_mvv)
         `CHK("reliable", !c[2], open_rel)
      end
      v = 16'($urandom);
      adc_data <= v;
      cfg(250, 0, 0);
      gap(msbr_pkg::CYC_50);
      frames(2);
      check_frame(8'h00, exp_count(250, 50), v);
      adc_open <= 1'b1;
      adc_err <= 1'b1;
      while (conv_stb !== 1'b1) @(posedge sys_clk_i);
      adc_open <= 1'b0;
      frames(1);
      `CHK("irq_open", 1'b1, r[1])
      check_frame(8'h03, exp_count(250, 50), v);
      adc_err <= 1'b0;
      v = 16'($urandom);
      adc_data <= v;
      cfg(350, 0, 1);
      frames(1);
      apb(1'b0, msbr_pkg::H_SAMPLE_BASE, 32'h0);
      `CHK("nosync", 32'h4, r)
      cfg(300, 0, 1);
      gap(msbr_pkg::CYC_100);
      frames(2);
      check_frame(8'h00, exp_count(300, 100), v);
      wrap_up();
   end
endmodule : tb
